//--- pfifo_pkg.sv
// package: constants and carrier types for the parallel fifo host port
// assumes a 100 MHz core clock
package pfifo_pkg;
	localparam int unsigned clock_period_ns = 10;
	localparam int unsigned data_width = 8;
	localparam int unsigned fifo_depth = 4;
	// flag inactive hold after a transfer, in ns
	localparam int unsigned flag_hold_ns = 80;
	localparam int unsigned flag_hold_cycles =
		(flag_hold_ns + clock_period_ns - 1) / clock_period_ns;
	localparam logic [3:0] flag_hold_init = 4'(flag_hold_cycles);
	localparam logic [3:0] count_zero = 4'h0;
	localparam logic [3:0] count_one = 4'h1;
	localparam logic [2:0] sync_reset = 3'h7;
	localparam logic [2:0] sync_low = 3'h0;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} byte_beat_t;

	typedef enum logic [0:0] {
		flag_ready,
		flag_hold
	} flag_state_t;
endpackage : pfifo_pkg

//--- parallel_fifo_host_port.sv
// holds the byte fifo and the parallel fifo host port
// assumes strobes arrive asynchronously from an external host
//
// Contract
// - port drives pins and flags only when parallel fifo mode is selected.
// - rx_avail_n low when a byte waits outside the post-read hold; host reads by pulsing strobe.
// - tx_space_n low when a byte can be accepted.
// - drive current byte while read strobe low, release lines otherwise.
// - each read strobe falling edge advances to next receive byte.
// - each write strobe falling edge captures data bus into transmit fifo.
// - rx_avail_n held high at least 80 ns after each read.
// - tx_space_n held high at least 80 ns after each write.
`timescale 1ns/1ps

module byte_fifo #(
	parameter int unsigned width = 8,
	parameter int unsigned depth = 4
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int unsigned aw = $clog2(depth);
	logic [width-1:0] mem [depth];
	logic [aw-1:0] rd_ptr;
	logic [aw-1:0] wr_ptr;
	logic [aw:0] count;
	logic [aw-1:0] next_rd_ptr;
	logic [aw-1:0] next_wr_ptr;
	logic [aw:0] next_count;
	logic push;
	logic pop;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? aw'((wr_ptr + 1'b1) % depth) : wr_ptr;
		next_rd_ptr = pop ? aw'((rd_ptr + 1'b1) % depth) : rd_ptr;
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign in_ready = count < (aw+1)'(depth);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];

	a_fifo_no_overflow: assert property (@(posedge clock) disable iff (!resetn)
		count <= (aw+1)'(depth))
		else $error("fifo count above depth");
endmodule : byte_fifo

module parallel_fifo_host_port (
	input wire logic clock,
	input wire logic resetn,
	input wire logic fifo_mode,
	input wire logic read_strobe_n,
	input wire logic write_strobe,
	input wire logic [7:0] fifo_data_bus_in,
	output logic [7:0] fifo_data_bus_out,
	output logic fifo_data_bus_oe,
	output logic rx_avail_n,
	output logic tx_space_n,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready
);
	// ------------------------------------------------------------
	// strobe and mode synchronisers
	// ------------------------------------------------------------
	logic [2:0] rd_sync;
	logic [2:0] wr_sync;
	logic [2:0] mode_sync;
	logic rd_low;
	logic wr_high;
	logic mode_on;
	logic [2:0] next_rd_sync;
	logic [2:0] next_wr_sync;
	logic [2:0] next_mode_sync;
	logic next_rd_low;
	logic next_wr_high;
	logic next_mode_on;
	logic rd_fall;
	logic wr_fall;

	always_comb begin
		next_rd_sync = {rd_sync[1:0], read_strobe_n};
		next_wr_sync = {wr_sync[1:0], write_strobe};
		next_mode_sync = {mode_sync[1:0], fifo_mode};
		// a change counts once stages two and three agree
		next_rd_low = (rd_sync[1] == rd_sync[2]) ? !rd_sync[2] : rd_low;
		next_wr_high = (wr_sync[1] == wr_sync[2]) ? wr_sync[2] : wr_high;
		next_mode_on = (mode_sync[1] == mode_sync[2]) ? mode_sync[2] : mode_on;
		rd_fall = next_rd_low && !rd_low;
		wr_fall = !next_wr_high && wr_high;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_sync <= pfifo_pkg::sync_reset;
			wr_sync <= pfifo_pkg::sync_low;
			mode_sync <= pfifo_pkg::sync_low;
			rd_low <= 1'b0;
			wr_high <= 1'b0;
			mode_on <= 1'b0;
		end else begin
			rd_sync <= next_rd_sync;
			wr_sync <= next_wr_sync;
			mode_sync <= next_mode_sync;
			rd_low <= next_rd_low;
			wr_high <= next_wr_high;
			mode_on <= next_mode_on;
		end
	end

	// ------------------------------------------------------------
	// receive path: byte popped into cur between strobes, consumed on read strobe fall
	// ------------------------------------------------------------
	logic rxq_valid;
	logic [7:0] rxq_data;
	logic rx_pop;
	pfifo_pkg::byte_beat_t cur;
	pfifo_pkg::byte_beat_t next_cur;
	pfifo_pkg::flag_state_t rx_state;
	pfifo_pkg::flag_state_t next_rx_state;
	logic [3:0] rx_count;
	logic [3:0] next_rx_count;

	byte_fifo #(.width(pfifo_pkg::data_width), .depth(pfifo_pkg::fifo_depth))
	rx_q (
		.clock(clock),
		.resetn(resetn),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.in_data(rx_data),
		.out_valid(rxq_valid),
		.out_ready(rx_pop),
		.out_data(rxq_data)
	);

	always_comb begin
		next_cur = cur;
		rx_pop = 1'b0;
		next_rx_state = rx_state;
		next_rx_count = rx_count;
		if (mode_on && rd_fall && cur.valid) begin
			next_cur.valid = 1'b0;
		end else if (!cur.valid && rxq_valid && !rd_low) begin
			// load next byte only between strobes
			next_cur.data = rxq_data;
			next_cur.valid = 1'b1;
			rx_pop = 1'b1;
		end
		case (rx_state)
			pfifo_pkg::flag_ready: begin
				if (mode_on && rd_fall) begin
					next_rx_state = pfifo_pkg::flag_hold;
					next_rx_count = pfifo_pkg::flag_hold_init;
				end
			end
			pfifo_pkg::flag_hold: begin
				if (rx_count > pfifo_pkg::count_one) begin
					next_rx_count = rx_count - pfifo_pkg::count_one;
				end else if (!rd_low) begin
					next_rx_count = pfifo_pkg::count_zero;
					next_rx_state = pfifo_pkg::flag_ready;
				end
			end
			default: begin
				next_rx_state = pfifo_pkg::flag_ready;
			end
		endcase
	end

	// ------------------------------------------------------------
	// transmit path: bus captured on write strobe fall
	// ------------------------------------------------------------
	logic [7:0] bus_q1;
	logic [7:0] bus_q2;
	logic [7:0] bus_q3;
	logic txq_ready;
	logic tx_push;
	pfifo_pkg::flag_state_t tx_state;
	pfifo_pkg::flag_state_t next_tx_state;
	logic [3:0] tx_count;
	logic [3:0] next_tx_count;
	logic txq_valid;
	logic [7:0] txq_data;

	// data is stable while the strobe settles through the synchroniser
	always_ff @(posedge clock) begin
		bus_q1 <= fifo_data_bus_in;
		bus_q2 <= bus_q1;
		bus_q3 <= bus_q2;
	end

	assign tx_push = mode_on && wr_fall;

	byte_fifo #(.width(pfifo_pkg::data_width), .depth(pfifo_pkg::fifo_depth))
	tx_q (
		.clock(clock),
		.resetn(resetn),
		.in_valid(tx_push),
		.in_ready(txq_ready),
		.in_data(bus_q3),
		.out_valid(txq_valid),
		.out_ready(tx_ready),
		.out_data(txq_data)
	);

	always_comb begin
		next_tx_state = tx_state;
		next_tx_count = tx_count;
		case (tx_state)
			pfifo_pkg::flag_ready: begin
				if (tx_push) begin
					next_tx_state = pfifo_pkg::flag_hold;
					next_tx_count = pfifo_pkg::flag_hold_init;
				end
			end
			pfifo_pkg::flag_hold: begin
				if (tx_count > pfifo_pkg::count_one) begin
					next_tx_count = tx_count - pfifo_pkg::count_one;
				end else begin
					next_tx_count = pfifo_pkg::count_zero;
					next_tx_state = pfifo_pkg::flag_ready;
				end
			end
			default: begin
				next_tx_state = pfifo_pkg::flag_ready;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state and registered outputs
	// ------------------------------------------------------------
	logic next_rx_avail_n;
	logic next_tx_space_n;
	logic next_oe;

	always_comb begin
		next_rx_avail_n = !(mode_on && next_cur.valid &&
			next_rx_state == pfifo_pkg::flag_ready);
		next_tx_space_n = !(mode_on && txq_ready &&
			next_tx_state == pfifo_pkg::flag_ready && !next_wr_high);
		next_oe = mode_on && next_rd_low;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cur <= '0;
			rx_state <= pfifo_pkg::flag_ready;
			rx_count <= pfifo_pkg::count_zero;
			tx_state <= pfifo_pkg::flag_ready;
			tx_count <= pfifo_pkg::count_zero;
			rx_avail_n <= 1'b1;
			tx_space_n <= 1'b1;
			fifo_data_bus_oe <= 1'b0;
			fifo_data_bus_out <= '0;
			tx_data <= '0;
			tx_valid <= 1'b0;
		end else begin
			cur <= next_cur;
			rx_state <= next_rx_state;
			rx_count <= next_rx_count;
			tx_state <= next_tx_state;
			tx_count <= next_tx_count;
			rx_avail_n <= next_rx_avail_n;
			tx_space_n <= next_tx_space_n;
			fifo_data_bus_oe <= next_oe;
			fifo_data_bus_out <= cur.data;
			tx_data <= txq_data;
			tx_valid <= txq_valid;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_rx_flag_hold: assert property (@(posedge clock) disable iff (!resetn)
		(mode_on && rd_fall) |=> rx_avail_n [*8])
		else $error("rx flag low too soon after read");
	a_tx_flag_hold: assert property (@(posedge clock) disable iff (!resetn)
		tx_push |=> tx_space_n [*8])
		else $error("tx flag low too soon after write");
	a_bus_drive_read: assert property (@(posedge clock) disable iff (!resetn)
		fifo_data_bus_oe == $past(mode_on && next_rd_low))
		else $error("bus drive not following read strobe");
	a_mode_off_quiet: assert property (@(posedge clock) disable iff (!resetn)
		!$past(mode_on) |-> (rx_avail_n && tx_space_n && !fifo_data_bus_oe))
		else $error("port active outside fifo mode");
	a_rx_flag_data: assert property (@(posedge clock) disable iff (!resetn)
		!rx_avail_n |-> cur.valid)
		else $error("rx flag low with no byte");
	a_read_advance: assert property (@(posedge clock) disable iff (!resetn)
		(mode_on && rd_fall && cur.valid) |=> !cur.valid)
		else $error("read did not consume byte");
	a_write_capture: assert property (@(posedge clock) disable iff (!resetn)
		(tx_push && txq_ready && !tx_ready) |=> txq_valid)
		else $error("write not captured");
	a_tx_flag_space: assert property (@(posedge clock) disable iff (!resetn)
		!tx_space_n |-> $past(txq_ready))
		else $error("tx flag low with full fifo");
	c_read_done: cover property (@(posedge clock) disable iff (!resetn)
		mode_on && rd_fall && cur.valid);
	c_write_done: cover property (@(posedge clock) disable iff (!resetn)
		tx_push);
	c_tx_full: cover property (@(posedge clock) disable iff (!resetn)
		!txq_ready);
endmodule : parallel_fifo_host_port

//--- host_model.sv
// host model: external controller pacing strobes on the parallel fifo port
// assumes the device core clock is shared only to time its own strobes
`timescale 1ns/1ps

module host_model (
	input wire logic clock,
	input wire logic [7:0] dev_out,
	input wire logic dev_oe,
	input wire logic rx_avail_n,
	input wire logic tx_space_n,
	output logic read_strobe_n,
	output logic write_strobe,
	output logic [7:0] bus
);
	logic drive;
	logic [7:0] wdata;
	logic [7:0] idle;
	int n;

	// ------------------------------------------------------------
	// bus resolution
	// ------------------------------------------------------------
	initial begin
		read_strobe_n = 1'b1;
		write_strobe = 1'b0;
		drive = 1'b0;
		wdata = 8'h00;
		idle = 8'h5a;
	end
	// released bus toggles so stale data never looks valid
	always @(posedge clock) begin
		idle <= ~idle;
	end
	assign bus = dev_oe ? dev_out : (drive ? wdata : idle);

	// ------------------------------------------------------------
	// strobes
	// ------------------------------------------------------------
	task automatic wait_flag(input bit tx);
		n = 0;
		while ((tx ? tx_space_n : rx_avail_n) !== 1'b0 && n < 200) begin
			@(posedge clock);
			n++;
		end
	endtask : wait_flag

	task automatic read_byte(output logic [7:0] d, output logic oe_seen);
		wait_flag(1'b0);
		@(posedge clock);
		read_strobe_n <= 1'b0;
		repeat (6) @(posedge clock);
		d = bus;
		oe_seen = dev_oe;
		read_strobe_n <= 1'b1;
		repeat (13) @(posedge clock);
	endtask : read_byte

	task automatic write_byte(input logic [7:0] v);
		wait_flag(1'b1);
		@(posedge clock);
		wdata <= v;
		drive <= 1'b1;
		write_strobe <= 1'b1;
		repeat (5) @(posedge clock);
		write_strobe <= 1'b0;
		repeat (4) @(posedge clock);
		drive <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : write_byte
endmodule : host_model

//--- tb.sv
// testbench: parallel fifo host port against the host model
// assumes a 100 MHz clock and the hand-over timing of the port
`timescale 1ns/1ps

module tb;
	logic clock, resetn, fifo_mode, rx_valid, tx_ready;
	logic [7:0] rx_data;
	wire logic rd_n, wr, oe, rx_avail_n, tx_space_n, rx_ready, tx_valid;
	wire logic [7:0] bus, bus_out, tx_data;
	int error_cnt, checks, rx_hi, tx_hi, n;
	bit watch;
	logic [7:0] d;
	logic o;

	parallel_fifo_host_port parallel_fifo_host_port_i (.clock(clock),
		.resetn(resetn), .fifo_mode(fifo_mode), .read_strobe_n(rd_n),
		.write_strobe(wr), .fifo_data_bus_in(bus),
		.fifo_data_bus_out(bus_out), .fifo_data_bus_oe(oe),
		.rx_avail_n(rx_avail_n), .tx_space_n(tx_space_n),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
	host_model host_model_i (.clock(clock), .dev_out(bus_out), .dev_oe(oe),
		.rx_avail_n(rx_avail_n), .tx_space_n(tx_space_n),
		.read_strobe_n(rd_n), .write_strobe(wr), .bus(bus));

	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// flag high spans measured at each fall
	always @(posedge clock) begin
		if (watch && rx_hi != 0 && rx_avail_n === 1'b0)
			chk("rx_hold", 8'(rx_hi >= 8), 8'h01);
		if (watch && tx_hi != 0 && tx_space_n === 1'b0)
			chk("tx_hold", 8'(tx_hi >= 8), 8'h01);
		rx_hi <= (rx_avail_n === 1'b1) ? rx_hi + 1 : 0;
		tx_hi <= (tx_space_n === 1'b1) ? tx_hi + 1 : 0;
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		repeat (3) @(posedge clock);
		chk("rst_rx_flag", 8'(rx_avail_n), 8'h01);
		chk("rst_oe", 8'(oe), 8'h00);
		@(posedge clock);
		resetn <= 1'b1;
		repeat (12) @(posedge clock);
		chk("empty_rx_flag", 8'(rx_avail_n), 8'h01);
		chk("empty_tx_flag", 8'(tx_space_n), 8'h00);
		watch = 1'b1;
	endtask : t_reset

	task automatic t_read;
		for (int i = 0; i < 4; i++) begin
			rx_valid <= 1'b1;
			rx_data <= 8'ha5 + 8'(i * 37);
			@(posedge clock);
			chk("rx_ready", 8'(rx_ready), 8'h01);
		end
		rx_valid <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			host_model_i.read_byte(d, o);
			chk("rx_byte", d, 8'ha5 + 8'(i * 37));
			chk("rd_oe", 8'(o), 8'h01);
			chk("oe_release", 8'(oe), 8'h00);
		end
		repeat (20) @(posedge clock);
		chk("drained_rx_flag", 8'(rx_avail_n), 8'h01);
	endtask : t_read

	task automatic t_write;
		for (int i = 0; i < 4; i++)
			host_model_i.write_byte(8'h3c + 8'(i * 71));
		repeat (20) @(posedge clock);
		chk("full_tx_flag", 8'(tx_space_n), 8'h01);
		for (int i = 0; i < 4; i++) begin
			n = 0;
			while (tx_valid !== 1'b1 && n < 50) begin
				@(posedge clock);
				n++;
			end
			chk("tx_byte", tx_data, 8'h3c + 8'(i * 71));
			tx_ready <= 1'b1;
			@(posedge clock);
			tx_ready <= 1'b0;
			repeat (2) @(posedge clock);
		end
		repeat (20) @(posedge clock);
		chk("space_again", 8'(tx_space_n), 8'h00);
	endtask : t_write

	task automatic t_mode_off;
		watch = 1'b0;
		fifo_mode <= 1'b0;
		rx_valid <= 1'b1;
		rx_data <= 8'h69;
		@(posedge clock);
		rx_valid <= 1'b0;
		repeat (10) @(posedge clock);
		chk("off_rx_flag", 8'(rx_avail_n), 8'h01);
		host_model_i.read_byte(d, o);
		chk("off_oe", 8'(o), 8'h00);
	endtask : t_mode_off

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	always #5 clock = ~clock;

	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		fifo_mode = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
		t_reset();
		t_read();
		t_write();
		t_mode_off();
		finish_test();
	end

	initial begin
		#100us;
		error_cnt++;
		finish_test();
	end
endmodule : tb
